// ---- design/term_device.sv ----
// device end: termination latency, dynamic switch, write start, zq
// assumes controller keeps its side of the link timing
// What this block does
// - termination on/off at write latency minus two
// - nominal to write termination at WL-2
// - chopped write returns nominal by 4+off
// - full write returns nominal by 6+off
// - controller holds odt WL-1 around power-down
// - full/otf writes start four after WL
// - fixed chop writes start two after WL
// - reads only with locked dll; odt is not gated by dll lock
// - cke low allowed during busy operations
// - cke low only after refresh minimum
// - short calibration completes within 64 cycles
// - bench rounds write recovery up; controller does no rounding
// - clock period limited only by refresh
// - no termination during self refresh
`timescale 1ns/1ps
`default_nettype none
`include "term_timing_params.svh"
module term_device
(
  // clock and reset
  input  wire logic                         core_clk_i,
  input  wire logic                         resetn_i,
  // link
  term_link_if.device                       link,
  // user side
  input  wire logic                         dll_locked_i,
  output logic [1:0]                        term_state_o,
  output logic                              write_start_o,
  output logic                              zq_busy_o,
  output logic                              self_refresh_o
);
  // whole state of the device end
  typedef struct packed
  {
    logic [15:0] odt_pipe;     // odt history, bit n = n+1 cycles ago
    logic [15:0] wr_pipe;      // write history
    logic [15:0] chop_pipe;    // chop flag history
    logic [3:0]  wr_hold;      // cycles left in write termination
    logic [15:0] start_pipe;   // write-start delay line
    logic [6:0]  zq_cnt;       // calibration countdown
    logic        sref;         // in self refresh
    logic [1:0]  term;         // termination state
    logic        wstart;       // internal write start pulse
    logic        dll;          // locked status out
    logic        zq_busy;      // calibration running, registered for the pin
  } dev_state_t;

  dev_state_t st_reg;
  dev_state_t st_next;
  logic [3:0] lat;             // write latency minus two
  logic [3:0] wsd;             // write start delay

  // tap from a history vector, lat 0 means this cycle
  function automatic logic tap(input logic [15:0] p, input logic cur, input logic [3:0] d);
    tap = (d == 4'h0) ? cur : p[d - 4'h1];
  endfunction : tap

  always_comb
  begin
    st_next = st_reg;
    lat = link.wl - `TERM_LAT_SUB;
    // fixed chop writes finish their burst earlier
    wsd = link.wl + (link.chop_fixed ? `WSTART_CHOP_FIXED : `WSTART_FULL);
    st_next.odt_pipe = {st_reg.odt_pipe[14:0], link.odt};
    st_next.wr_pipe = {st_reg.wr_pipe[14:0], link.cmd == term_timing_pkg::CMD_WRITE};
    st_next.chop_pipe = {st_reg.chop_pipe[14:0], link.chop};
    st_next.start_pipe = {st_reg.start_pipe[14:0], link.cmd == term_timing_pkg::CMD_WRITE};
    st_next.wstart = tap(st_reg.start_pipe, link.cmd == term_timing_pkg::CMD_WRITE, wsd);
    // self refresh tracking
    if (link.cmd == term_timing_pkg::CMD_SRE)
      st_next.sref = 1'b1;
    else if (link.cmd == term_timing_pkg::CMD_SRX)
      st_next.sref = 1'b0;
    if (link.cmd == term_timing_pkg::CMD_SHORT_IMPEDANCE_CALIBRATION)
      st_next.zq_cnt = `SHORT_IMPEDANCE_CALIBRATION_CYCLES - 7'h1;
    else if (st_reg.zq_cnt != 7'h0)
      st_next.zq_cnt = st_reg.zq_cnt - 7'h1;
    // switch to write term
    // write termination only where odt was up for that write
    if (tap(st_reg.wr_pipe, link.cmd == term_timing_pkg::CMD_WRITE, lat)
        && tap(st_reg.odt_pipe, link.odt, lat))
      st_next.wr_hold = tap(st_reg.chop_pipe, link.chop, lat) ? `WTN_EXTRA_CHOP : `WTN_EXTRA_FULL;
    else if (st_reg.wr_hold != 4'h0)
      st_next.wr_hold = st_reg.wr_hold - 4'h1;
    if (st_reg.sref || link.cmd == term_timing_pkg::CMD_SRE)
      st_next.term = term_timing_pkg::TERM_OFF;
    else if (st_next.wr_hold != 4'h0)
      st_next.term = term_timing_pkg::TERM_WR;
    else if (tap(st_reg.odt_pipe, link.odt, lat))
      st_next.term = term_timing_pkg::TERM_NOM;
    else
      st_next.term = term_timing_pkg::TERM_OFF;
    st_next.dll = dll_locked_i;
    // busy flag from the next count, so the pin keeps the count's timing
    st_next.zq_busy = (st_next.zq_cnt != 7'h0);
  end

  // state register
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign link.dll_locked = st_reg.dll;
  assign term_state_o    = st_reg.term;
  assign write_start_o   = st_reg.wstart;
  assign zq_busy_o       = st_reg.zq_busy;
  assign self_refresh_o  = st_reg.sref;
endmodule : term_device
`default_nettype wire

// ---- include/term_timing_params.svh ----
// timing constants for the termination latency model
// assumes write latency is supplied as a cycle count of at least 5
`ifndef TERM_TIMING_PARAMS_SVH
`define TERM_TIMING_PARAMS_SVH
// termination latency is write latency minus this
`define TERM_LAT_SUB        4'h2
// power-down hold is write latency minus this
`define TERM_PD_HOLD_SUB    4'h1
// extra cycles after turn-off latency, chopped and full bursts
`define WTN_EXTRA_CHOP      4'h4
`define WTN_EXTRA_FULL      4'h6
// internal write start after write latency
`define WSTART_FULL         4'h4
`define WSTART_CHOP_FIXED   4'h2
// short calibration bound, cycles
`define SHORT_IMPEDANCE_CALIBRATION_CYCLES         7'h40
// clock period in ps for recovery rounding
`define CLK_PERIOD_PS       16'h61a8
// write recovery time default, ps
`define WRITE_RECOVERY_PS   16'h3a98
// refresh to power-down minimum, cycles
`define REF_PD_CYCLES       4'h1
`endif

// ---- include/term_timing_pkg.sv ----
// types shared by both ends of the termination link
// assumes nothing beyond the params header
package term_timing_pkg;
  // termination state driven onto the bus
  typedef enum logic [1:0]
  {
    TERM_OFF = 2'b00,
    TERM_NOM = 2'b01,
    TERM_WR  = 2'b10
  } term_state_t;
  // command on the link
  typedef enum logic [2:0]
  {
    CMD_NOP   = 3'b000,
    CMD_WRITE = 3'b001,
    CMD_READ  = 3'b010,
    CMD_REF   = 3'b011,
    CMD_SHORT_IMPEDANCE_CALIBRATION  = 3'b100,
    CMD_SRE   = 3'b101,
    CMD_SRX   = 3'b110
  } cmd_t;
endpackage : term_timing_pkg

// ---- include/term_link_if.sv ----
// link between controller end and device end
// assumes both ends share core_clk_i
`timescale 1ns/1ps
`default_nettype none
interface term_link_if;
  logic                   odt;       // on_die_termination_input
  logic                   cke;       // clock enable
  term_timing_pkg::cmd_t  cmd;       // command strobe, one cycle
  logic                   chop;      // write is chopped_four_beat_burst
  logic                   chop_fixed;// burst chop fixed by mode
  logic [3:0]             wl;        // write_latency_cycles
  logic                   dll_locked;// device dll status
  modport device (input odt, cke, cmd, chop, chop_fixed, wl, output dll_locked);
  modport ctrl   (output odt, cke, cmd, chop, chop_fixed, wl, input dll_locked);
endinterface : term_link_if
`default_nettype wire

// ---- design/term_ctrl.sv ----
// controller end: drives odt, cke and commands with spacing
// assumes device end on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "term_timing_params.svh"
module term_ctrl
(
  // clock and reset
  input  wire logic                 core_clk_i,
  input  wire logic                 resetn_i,
  // link
  term_link_if.ctrl                 link,
  // user side
  input  wire logic                 odt_req_i,
  input  wire logic                 pd_req_i,
  input  wire logic [2:0]           cmd_req_i,
  input  wire logic                 chop_i,
  input  wire logic                 chop_fixed_i,
  input  wire logic [3:0]           wl_i,
  output logic                      cmd_drop_o
);
  typedef struct packed
  {
    logic        odt;
    logic        cke;
    logic [2:0]  cmd;
    logic        chop;
    logic        chop_fixed;
    logic [3:0]  wl;
    logic [3:0]  odt_stable;  // cycles odt unchanged, saturating
    logic [3:0]  ref_cnt;     // cycles since refresh
    logic        drop;
  } ctl_state_t;
  ctl_state_t s_reg;
  ctl_state_t s_next;
  logic       ok;
  always_comb
  begin
    s_next = s_reg;
    s_next.wl = wl_i;
    s_next.chop = chop_i;
    s_next.chop_fixed = chop_fixed_i;
    ok = !(cmd_req_i == 3'(term_timing_pkg::CMD_READ) && !link.dll_locked);
    s_next.cmd = ok ? cmd_req_i : 3'(term_timing_pkg::CMD_NOP);
    s_next.drop = !ok;
    s_next.odt = (s_reg.cke != pd_req_i) ? odt_req_i : s_reg.odt;
    if (s_next.odt != s_reg.odt)
      s_next.odt_stable = 4'h0;
    else if (s_reg.odt_stable != 4'hf)
      s_next.odt_stable = s_reg.odt_stable + 4'h1;
    if (cmd_req_i == 3'(term_timing_pkg::CMD_REF))
      s_next.ref_cnt = 4'h0;
    else if (s_reg.ref_cnt != 4'hf)
      s_next.ref_cnt = s_reg.ref_cnt + 4'h1;
    if (pd_req_i && s_reg.ref_cnt >= `REF_PD_CYCLES
        && s_reg.odt_stable >= s_reg.wl - `TERM_PD_HOLD_SUB)
      s_next.cke = 1'b0;
    else if (!pd_req_i && s_reg.odt_stable >= s_reg.wl - `TERM_PD_HOLD_SUB)
      s_next.cke = 1'b1;
  end
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      s_reg <= '{cke: 1'b1, wl: 4'h5, ref_cnt: 4'hf, default: '0};
    else
      s_reg <= s_next;
  end
  assign link.odt        = s_reg.odt;
  assign link.cke        = s_reg.cke;
  assign link.cmd        = term_timing_pkg::cmd_t'(s_reg.cmd);
  assign link.chop       = s_reg.chop;
  assign link.chop_fixed = s_reg.chop_fixed;
  assign link.wl         = s_reg.wl;
  assign cmd_drop_o      = s_reg.drop;
endmodule : term_ctrl
`default_nettype wire

// ---- verif/term_link_sva.sv ----
// checker for the termination link and the device outputs
// assumes one clock, write latency held at 5 while traffic runs
`timescale 1ns/1ps
`default_nettype none
module term_link_sva
(
  // clock and reset
  input wire logic                  core_clk_i,
  input wire logic                  resetn_i,
  // link
  input wire logic                  odt,
  input wire logic                  cke,
  input wire term_timing_pkg::cmd_t cmd,
  input wire logic                  chop,
  input wire logic                  chop_fixed,
  input wire logic [3:0]            wl,
  input wire logic                  dll_locked,
  // device outputs
  input wire logic [1:0]            term_state_o,
  input wire logic                  write_start_o,
  input wire logic                  zq_busy_o,
  input wire logic                  self_refresh_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  logic       odt_q;    // odt at the previous edge
  logic [3:0] odt_same; // edges odt unchanged, saturating
  // stability count; one edge of slack for the register between them
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      odt_q    <= 1'b0;
      odt_same <= 4'h0;
    end
    else
    begin
      odt_q    <= odt;
      odt_same <= (odt != odt_q) ? 4'h0 : (odt_same == 4'hf ? 4'hf : odt_same + 4'h1);
    end
  end
  term_on_a: assert property ($rose(odt) && !self_refresh_o |-> ##[4:6] term_state_o == 2'h1)
    else $error("termination on late");
  term_off_a: assert property ($fell(odt) && !self_refresh_o |-> ##[4:6] term_state_o == 2'h0)
    else $error("termination off late");
  chop_back_a: assert property (cmd == term_timing_pkg::CMD_WRITE && odt && chop
    |-> ##[4:6] term_state_o == 2'h2 ##[1:6] term_state_o == 2'h1) else $error("chop write term");
  full_back_a: assert property (cmd == term_timing_pkg::CMD_WRITE && odt && !chop
    |-> ##[4:6] term_state_o == 2'h2 ##[1:8] term_state_o == 2'h1) else $error("full write term");
  wstart_full_a: assert property (cmd == term_timing_pkg::CMD_WRITE && !chop_fixed
    |-> ##[9:11] write_start_o) else $error("write start late");
  wstart_chop_a: assert property (cmd == term_timing_pkg::CMD_WRITE && chop_fixed
    |-> ##[7:9] write_start_o) else $error("fixed chop start late");
  read_lock_a: assert property (cmd == term_timing_pkg::CMD_READ |-> dll_locked)
    else $error("read while unlocked");
  ref_gap_a: assert property (cmd == term_timing_pkg::CMD_REF |=> !$fell(cke))
    else $error("cke low right after refresh");
  pd_hold_a: assert property ($changed(cke) |-> odt_same >= wl - 4'h2)
    else $error("odt not held around power-down");
  zq_bound_a: assert property (cmd == term_timing_pkg::CMD_SHORT_IMPEDANCE_CALIBRATION
    |-> ##[1:3] zq_busy_o ##[1:64] !zq_busy_o) else $error("calibration too long");
  sr_term_a: assert property (self_refresh_o && $past(self_refresh_o) |-> term_state_o == 2'h0)
    else $error("termination in self refresh");
endmodule : term_link_sva
`default_nettype wire

// ---- verif/ddr3_odt_latency_timing_bench.sv ----
// bench: controller end and device end joined by the link
// assumes write latency 5 and a 40 MHz clock
`timescale 1ns/1ps
`default_nettype none
`include "term_timing_params.svh"
module ddr3_odt_latency_timing_bench;
  logic core_clk_i, resetn_i, odt_req_i, pd_req_i, chop_i, chop_fixed_i, dll_locked_i;
  logic [2:0] cmd_req_i;
  logic [3:0] wl_i;
  logic [1:0] term_state_o;
  logic write_start_o, zq_busy_o, self_refresh_o, cmd_drop_o;
  int fails, checked, n, i;
  term_link_if link();
  term_ctrl i_term_ctrl (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .link(link),
    .odt_req_i(odt_req_i), .pd_req_i(pd_req_i), .cmd_req_i(cmd_req_i), .chop_i(chop_i),
    .chop_fixed_i(chop_fixed_i), .wl_i(wl_i), .cmd_drop_o(cmd_drop_o));
  term_device i_term_device (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .link(link),
    .dll_locked_i(dll_locked_i), .term_state_o(term_state_o), .write_start_o(write_start_o),
    .zq_busy_o(zq_busy_o), .self_refresh_o(self_refresh_o));
  term_link_sva i_term_link_sva (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .odt(link.odt),
    .cke(link.cke), .cmd(link.cmd), .chop(link.chop), .chop_fixed(link.chop_fixed),
    .wl(link.wl), .dll_locked(link.dll_locked), .term_state_o(term_state_o),
    .write_start_o(write_start_o), .zq_busy_o(zq_busy_o), .self_refresh_o(self_refresh_o));
  // 25 ns clock; any period works while refresh interval is met
  initial
  begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      $display("BAD %0t got %h want %h", $time, seen, exp);
      fails++;
    end
  endtask : check
  // 1 when the elapsed count lies in the allowed window
  function automatic logic [7:0] in_rng(input int v, input int lo, input int hi);
    return {7'h0, (v >= lo && v <= hi)};
  endfunction : in_rng
  // one command cycle, then idle
  task automatic send(input logic [2:0] c, input logic ch, input logic cf);
    cmd_req_i = c;
    chop_i = ch;
    chop_fixed_i = cf;
    @(negedge core_clk_i);
    cmd_req_i = 3'h0;
  endtask : send
  // bounded wait; sel picks the watched output, counts falling edges
  task automatic wait_for(input int sel, input logic [1:0] exp, input int lim);
    logic hit;
    hit = 1'b0;
    n = 0;
    while (!hit && n < lim)
    begin
      @(negedge core_clk_i);
      n++;
      case (sel)
        0: hit = (term_state_o === exp);
        1: hit = (write_start_o === 1'b1);
        2: hit = (cmd_drop_o === 1'b1);
        3: hit = (zq_busy_o === exp[0]);
        default: hit = (link.cke === exp[0]);
      endcase
    end
    if (!hit)
    begin
      $display("BAD %0t wait expired", $time);
      fails++;
      finish_test();
    end
  endtask : wait_for
  initial
  begin
    {resetn_i, odt_req_i, pd_req_i, chop_i, chop_fixed_i, cmd_req_i} = '0;
    dll_locked_i = 1'b1;
    wl_i = 4'h5;
    repeat (8) @(negedge core_clk_i);
    resetn_i = 1'b1;
    // write start: full, on-the-fly chop, fixed chop
    for (i = 0; i < 3; i++)
    begin
      send(term_timing_pkg::CMD_WRITE, i > 0, i == 2);
      wait_for(1, 2'h0, 16);
      check(in_rng(n + 1, i == 2 ? 8 : 10, i == 2 ? 10 : 12), 8'h01);
    end
    $display("test write start done");
    odt_req_i = 1'b1;
    wait_for(0, 2'h1, 10);
    check(in_rng(n, 5, 7), 8'h01);
    for (i = 0; i < 2; i++)
    begin
      send(term_timing_pkg::CMD_WRITE, i == 1, 1'b0);
      wait_for(0, 2'h2, 10);
      check(in_rng(n + 1, 5, 7), 8'h01);
      wait_for(0, 2'h1, 10);
      check(in_rng(n, i == 1 ? 3 : 5, i == 1 ? 5 : 7), 8'h01);
    end
    $display("test dynamic termination done");
    send(term_timing_pkg::CMD_SHORT_IMPEDANCE_CALIBRATION, 1'b0, 1'b0);
    wait_for(3, 2'h1, 4);
    wait_for(3, 2'h0, 70);
    check(in_rng(n, 60, 64), 8'h01);
    dll_locked_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
    send(term_timing_pkg::CMD_READ, 1'b0, 1'b0);
    // drop pulse stands one cycle only, so look right after the send
    check({7'h0, cmd_drop_o}, 8'h01);
    check({5'h0, link.cmd}, 8'h00);
    @(negedge core_clk_i);
    check({7'h0, cmd_drop_o}, 8'h00);
    // write recovery rounds up to whole cycles
    check(8'((`WRITE_RECOVERY_PS + `CLK_PERIOD_PS - 16'h1) / `CLK_PERIOD_PS), 8'h01);
    dll_locked_i = 1'b1;
    $display("test calibration and lock done");
    send(term_timing_pkg::CMD_REF, 1'b0, 1'b0);
    pd_req_i = 1'b1;
    wait_for(4, 2'h0, 16);
    check({7'h0, link.odt}, 8'h01);
    pd_req_i = 1'b0;
    wait_for(4, 2'h1, 16);
    send(term_timing_pkg::CMD_SRE, 1'b0, 1'b0);
    wait_for(0, 2'h0, 8);
    check({6'h0, term_state_o}, 8'h00);
    send(term_timing_pkg::CMD_SRX, 1'b0, 1'b0);
    wait_for(0, 2'h1, 12);
    odt_req_i = 1'b0;
    wait_for(0, 2'h0, 10);
    check(in_rng(n, 5, 7), 8'h01);
    $display("test power states done");
    finish_test();
  end
endmodule : ddr3_odt_latency_timing_bench
`default_nettype wire
